//--- hw/ate_defs.vh
// Purpose: constants for the address table access engine
// Assumes: included by bare name; definitions only
// Notes:   register indices are word indices, byte address is four times the index
`ifndef ATE_DEFS_VH
`define ATE_DEFS_VH

// ****************************************
// register word indices
// ****************************************
`define IDX_CMD0   10'h11A
`define IDX_CMD1   10'h11B
`define IDX_CMD2   10'h11C
`define IDX_CMD3   10'h11D
`define IDX_CMD4   10'h11E
`define IDX_CMD5   10'h11F
`define IDX_RES0   10'h120
`define IDX_RES1   10'h121
`define IDX_RES2   10'h122
`define IDX_RES3   10'h123
`define IDX_RES4   10'h124
`define IDX_RES5   10'h125
`define REG_RESET  16'h0000

// ****************************************
// register fields
// ****************************************
`define F_OP       6:4
`define F_SEL      3:0
`define F_STATIC   12
`define F_INFO     8:0
`define F_PORTS    9:4
`define F_FID      3:0
`define F_BUSY     15
`define F_CODE     14:12

// ****************************************
// stored entry layout
// ****************************************
`define E_W        70
`define E_BAD      69
`define E_STATIC   68
`define E_OCC      67
`define E_INFO     66:58
`define E_PORTS    57:52
`define E_FID      51:48
`define E_MAC      47:0
`define E_RESET    70'h0

// ****************************************
// table geometry
// ****************************************
`define TBL_AW     6
`define TBL_N      64
`define IDX_LAST   6'h3F
`define PTR_END    7'h40
`define WAY_FIRST  2'h0
`define WAY_LAST   2'h3

// ****************************************
// operations, selectors, results
// ****************************************
`define OP_WRITE   3'h0
`define OP_ERASE   3'h1
`define OP_SEARCH  3'h2
`define OP_INIT    3'h3
`define SEL_CREATE 4'h7
`define SEL_ALL    4'hF
`define SEL_EMPTY  4'h0
`define SEL_FIRST  4'h0
`define SEL_MACPTR 4'h4
`define KEY_EN     3
`define KEY_MAC    2
`define KEY_FID    1
`define KEY_PORT   0
`define RES_OK     3'h0
`define RES_FULL   3'h1
`define RES_NONE   3'h2
`define RES_ERR    3'h5
`define M_CREATE   2'h0
`define M_OVER     2'h1
`define M_ERASE    2'h2
`define M_SRCH     2'h3

`endif

//--- hw/addr_table_store.v
// Purpose: storage of the 4-way address table, one registered read port, one write port
// Assumes: a read of the location being written returns the old contents
// Notes:   occupancy is kept in flip-flops so that reset empties the table
`timescale 1ns/10ps
`include "ate_defs.vh"

module addr_table_store (
    // clock and reset
    input  wire                 sys_clk,
    input  wire                 rst,
    // read port, data one cycle after address
    input  wire [`TBL_AW-1:0]   rd_addr,
    output reg  [`E_W-1:0]      rd_data,
    // write port
    input  wire                 wr_en,
    input  wire [`TBL_AW-1:0]   wr_addr,
    input  wire [`E_W-1:0]      wr_data
);

    reg  [`E_W-1:0]  mem [0:`TBL_N-1];
    wire [`TBL_N-1:0] occ;

    // ****************************************
    // occupancy, one flag per entry
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `TBL_N; g = g + 1) begin : g_occ
            localparam integer ADDR = g;
            reg occ_q;
            always @(posedge sys_clk) begin
                if (rst) begin
                    occ_q <= 1'b0;
                end else if (wr_en && wr_addr == ADDR[`TBL_AW-1:0]) begin
                    occ_q <= wr_data[`E_OCC];
                end
            end
            assign occ[g] = occ_q;
        end
    endgenerate

    // ****************************************
    // entry contents
    // ****************************************
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // free entries read as zero: never-written words would otherwise leak unknowns
    always @(posedge sys_clk) begin
        if (rst || !occ[rd_addr]) begin
            rd_data <= `E_RESET;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // addr_table_store

//--- hw/address_table_access_engine.v
// Purpose: software access engine for the MAC address learning table
// Assumes: classic Wishbone slave, 16-bit registers in the low half of each word
// Notes:   one table entry is examined every two clocks; a search scans at most 64 entries
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "ate_defs.vh"

module address_table_access_engine (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o
);

    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_READ  = 4'h2;
    localparam [3:0] S_CHECK = 4'h4;
    localparam [3:0] S_WRITE = 4'h8;

    reg              ack_q;
    reg  [31:0]      dat_q;
    reg  [3:0]       state_q;
    reg              busy_q;
    reg              go_q;
    reg  [6:0]       ptr_q;
    reg  [5:0]       idx_q;
    reg  [1:0]       mode_q;
    reg              hit_q;
    reg              free_q;
    reg              dyn_q;
    reg  [1:0]       hit_way_q;
    reg  [1:0]       free_way_q;
    reg  [1:0]       dyn_way_q;
    reg  [`E_W-1:0]  wdata_q;
    reg  [`E_W-1:0]  res_q;
    reg  [2:0]       code_q;
    reg  [15:0]      rd_mux_d;

    wire [9:0]       reg_idx;
    wire             req;
    wire             wr;
    wire [`E_W-1:0]  rd_data;
    wire [15:0]      cmd [0:5];

    assign reg_idx  = wb_adr_i[11:2];
    assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr       = req & wb_we_i;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************
    // command registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_cmd
            localparam integer IDX = `IDX_CMD0 + g;
            reg [15:0] val_q;
            always @(posedge sys_clk) begin
                if (rst) begin
                    val_q <= `REG_RESET;
                end else if (wr && !busy_q && reg_idx == IDX[9:0]) begin
                    if (wb_sel_i[0]) begin
                        val_q[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        val_q[15:8] <= wb_dat_i[15:8];
                    end
                end
            end
            assign cmd[g] = val_q;
        end
    endgenerate

    // command fields, same encoding as a stored entry
    wire [47:0] cmd_mac    = {cmd[2], cmd[1], cmd[0]};
    wire [3:0]  cmd_fid    = cmd[3][`F_FID];
    wire [5:0]  cmd_ports  = cmd[3][`F_PORTS];
    wire [8:0]  cmd_info   = cmd[4][`F_INFO];
    wire        cmd_static = cmd[4][`F_STATIC];
    wire [2:0]  op         = cmd[5][`F_OP];
    wire [3:0]  sel        = cmd[5][`F_SEL];
    wire [3:0]  hash       = cmd_mac[3:0] ^ cmd_mac[7:4] ^ cmd_fid;

    // ****************************************
    // table storage
    // ****************************************
    addr_table_store u_store (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rd_addr (idx_q),
        .rd_data (rd_data),
        .wr_en   (state_q == S_WRITE),
        .wr_addr (idx_q),
        .wr_data (wdata_q)
    );

    // ****************************************
    // entry compare
    // ****************************************
    wire e_occ    = rd_data[`E_OCC];
    wire e_static = rd_data[`E_STATIC];
    wire mac_eq   = rd_data[`E_MAC] == cmd_mac;
    wire fid_eq   = rd_data[`E_FID] == cmd_fid;
    // port key matches any shared output port
    wire port_any = |(rd_data[`E_PORTS] & cmd_ports);
    wire key_hit  = e_occ & mac_eq & fid_eq;
    wire key_srch = e_occ & (~sel[`KEY_MAC] | mac_eq) & (~sel[`KEY_FID] | fid_eq)
                    & (~sel[`KEY_PORT] | port_any);
    wire srch_hit = (sel == `SEL_EMPTY) ? ~e_occ : key_srch;

    // way bookkeeping including the entry now on the read port
    wire       hit_n      = hit_q | key_hit;
    wire       free_n     = free_q | ~e_occ;
    wire       dyn_n      = dyn_q | (e_occ & ~e_static);
    wire [1:0] hit_way_n  = hit_q ? hit_way_q : idx_q[1:0];
    wire [1:0] free_way_n = free_q ? free_way_q : idx_q[1:0];
    wire [1:0] dyn_way_n  = dyn_q ? dyn_way_q : idx_q[1:0];
    // an existing key is refreshed in place, else an empty way, else a dynamic one
    wire [1:0] new_way    = hit_n ? hit_way_n : (free_n ? free_way_n : dyn_way_n);
    wire [5:0] idx_inc    = idx_q + 6'h01;
    wire [6:0] idx_next   = {1'b0, idx_q} + 7'h01;

    wire [`E_W-1:0] new_entry = {1'b0, cmd_static, 1'b1, cmd_info, cmd_ports, cmd_fid, cmd_mac};
    wire [`E_W-1:0] gone_entry = {1'b0, cmd_static, 1'b0, cmd_info, cmd_ports, cmd_fid, cmd_mac};

    // ****************************************
    // operation engine
    // ****************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= S_IDLE;
            busy_q     <= 1'b0;
            go_q       <= 1'b0;
            ptr_q      <= 7'h00;
            idx_q      <= 6'h00;
            mode_q     <= `M_CREATE;
            hit_q      <= 1'b0;
            free_q     <= 1'b0;
            dyn_q      <= 1'b0;
            hit_way_q  <= `WAY_FIRST;
            free_way_q <= `WAY_FIRST;
            dyn_way_q  <= `WAY_FIRST;
            wdata_q    <= `E_RESET;
            res_q      <= `E_RESET;
            code_q     <= `RES_OK;
        end else begin
            go_q <= 1'b0;
            // busy rises on the very edge that takes the register 5 write
            if (wr && !busy_q && reg_idx == `IDX_CMD5) begin
                busy_q <= 1'b1;
                go_q   <= 1'b1;
            end
            case (state_q)
                S_IDLE: begin
                    if (go_q) begin
                        hit_q  <= 1'b0;
                        free_q <= 1'b0;
                        dyn_q  <= 1'b0;
                        idx_q  <= {hash, `WAY_FIRST};
                        case (op)
                            `OP_WRITE: begin
                                if (sel == `SEL_CREATE) begin
                                    mode_q  <= `M_CREATE;
                                    state_q <= S_READ;
                                end else if (sel == `SEL_ALL) begin
                                    mode_q  <= `M_OVER;
                                    state_q <= S_READ;
                                end else begin
                                    code_q <= `RES_ERR;
                                    busy_q <= 1'b0;
                                end
                            end
                            `OP_ERASE: begin
                                if (sel == `SEL_ALL) begin
                                    mode_q  <= `M_ERASE;
                                    state_q <= S_READ;
                                end else begin
                                    code_q <= `RES_ERR;
                                    busy_q <= 1'b0;
                                end
                            end
                            `OP_SEARCH: begin
                                if (sel != `SEL_EMPTY && !(sel[`KEY_EN] && sel[2:0] != 3'h0)) begin
                                    code_q <= `RES_ERR;
                                    busy_q <= 1'b0;
                                end else if (ptr_q == `PTR_END) begin
                                    code_q <= `RES_NONE;
                                    busy_q <= 1'b0;
                                end else begin
                                    mode_q  <= `M_SRCH;
                                    idx_q   <= ptr_q[5:0];
                                    state_q <= S_READ;
                                end
                            end
                            `OP_INIT: begin
                                if (sel == `SEL_MACPTR) begin
                                    ptr_q  <= {1'b0, hash, `WAY_FIRST};
                                    code_q <= `RES_OK;
                                end else if (sel == `SEL_FIRST) begin
                                    ptr_q  <= 7'h00;
                                    code_q <= `RES_OK;
                                end else begin
                                    code_q <= `RES_ERR;
                                end
                                busy_q <= 1'b0;
                            end
                            default: begin
                                code_q <= `RES_ERR;
                                busy_q <= 1'b0;
                            end
                        endcase
                    end
                end
                S_READ: begin
                    state_q <= S_CHECK;
                end
                S_CHECK: begin
                    if (mode_q == `M_SRCH) begin
                        if (srch_hit) begin
                            res_q   <= rd_data;
                            ptr_q   <= idx_next;
                            code_q  <= `RES_OK;
                            busy_q  <= 1'b0;
                            state_q <= S_IDLE;
                        end else if (idx_q == `IDX_LAST) begin
                            ptr_q   <= `PTR_END;
                            code_q  <= `RES_NONE;
                            busy_q  <= 1'b0;
                            state_q <= S_IDLE;
                        end else begin
                            idx_q   <= idx_inc;
                            state_q <= S_READ;
                        end
                    end else if (idx_q[1:0] != `WAY_LAST) begin
                        hit_q      <= hit_n;
                        free_q     <= free_n;
                        dyn_q      <= dyn_n;
                        hit_way_q  <= hit_way_n;
                        free_way_q <= free_way_n;
                        dyn_way_q  <= dyn_way_n;
                        idx_q      <= idx_inc;
                        state_q    <= S_READ;
                    end else if (mode_q == `M_CREATE) begin
                        if (hit_n || free_n || dyn_n) begin
                            idx_q   <= {idx_q[5:2], new_way};
                            wdata_q <= new_entry;
                            state_q <= S_WRITE;
                        end else begin
                            code_q  <= `RES_FULL;
                            busy_q  <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end else if (hit_n) begin
                        idx_q   <= {idx_q[5:2], hit_way_n};
                        wdata_q <= (mode_q == `M_ERASE) ? gone_entry : new_entry;
                        state_q <= S_WRITE;
                    end else begin
                        code_q  <= `RES_NONE;
                        busy_q  <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                S_WRITE: begin
                    code_q  <= `RES_OK;
                    busy_q  <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // register read mux
    // ****************************************
    always @* begin
        case (reg_idx)
            `IDX_CMD0: rd_mux_d = cmd[0];
            `IDX_CMD1: rd_mux_d = cmd[1];
            `IDX_CMD2: rd_mux_d = cmd[2];
            `IDX_CMD3: rd_mux_d = cmd[3];
            `IDX_CMD4: rd_mux_d = cmd[4];
            `IDX_CMD5: rd_mux_d = cmd[5];
            `IDX_RES0: rd_mux_d = res_q[15:0];
            `IDX_RES1: rd_mux_d = res_q[31:16];
            `IDX_RES2: rd_mux_d = res_q[47:32];
            `IDX_RES3: rd_mux_d = {6'h00, res_q[`E_PORTS], res_q[`E_FID]};
            `IDX_RES4: rd_mux_d = {7'h00, res_q[`E_INFO]};
            `IDX_RES5: rd_mux_d = {busy_q, code_q, 9'h000, res_q[`E_BAD], res_q[`E_OCC],
                                   res_q[`E_STATIC]};
            default:   rd_mux_d = 16'h0000;
        endcase
    end

    // ****************************************
    // wishbone answer
    // ****************************************
    // every access, mapped or not, is acked one cycle after it is taken
    always @(posedge sys_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                dat_q <= {16'h0000, rd_mux_d};
            end
        end
    end

endmodule // address_table_access_engine

//--- verification/address_table_access_engine_checker.sv
// Purpose: port-level assertions for the address table access engine
// Assumes: classic Wishbone master that releases the bus for a cycle after every ack
// Notes:   busy is only visible through reads of the result flags register
`timescale 1ns/10ps
module address_table_access_engine_checker (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o
);
    wire       take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       rd_take  = take && !wb_we_i;
    wire       cmd_take = take && wb_we_i && (wb_adr_i[11:2] == 10'h11F);
    reg        flags_q;
    reg        create_q;
    reg        pend_q;
    reg  [3:0] since_q;
    // dropped commands still set pend_q: weaker, but never a false alarm
    always @(posedge sys_clk) begin
        if (rst) begin
            flags_q  <= 1'b0;
            create_q <= 1'b0;
            pend_q   <= 1'b0;
            since_q  <= 4'hF;
        end else begin
            flags_q <= rd_take && (wb_adr_i[11:2] == 10'h125);
            since_q <= cmd_take ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
            if (cmd_take)
                create_q <= (wb_dat_i[6:0] == 7'h07);
            if (cmd_take)
                pend_q <= 1'b1;
            else if (flags_q && !wb_dat_o[15])
                pend_q <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_ack_follow; take |=> wb_ack_o; endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("ack missing");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_no_ack_idle; !take |=> !wb_ack_o; endproperty
    a_no_ack_idle: assert property (p_no_ack_idle) else $error("ack unasked");
    property p_upper_zero; wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000); endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper half set");
    property p_unmapped;
        rd_take && (wb_adr_i[11:2] < 10'h11A || wb_adr_i[11:2] > 10'h125) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dat_hold; !rd_take |=> $stable(wb_dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_busy_create; flags_q && create_q && since_q < 4'h8 |-> wb_dat_o[15]; endproperty
    a_busy_create: assert property (p_busy_create) else $error("busy low during create");
    property p_busy_cause; flags_q && wb_dat_o[15] |-> pend_q; endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
    property p_bad_zero; flags_q |-> !wb_dat_o[2]; endproperty
    a_bad_zero: assert property (p_bad_zero) else $error("fail mark set");
    c_busy: cover property (flags_q && wb_dat_o[15]);
    c_full: cover property (flags_q && wb_dat_o[14:12] == 3'h1);
    c_cmd: cover property (cmd_take);
endmodule // address_table_access_engine_checker
bind address_table_access_engine address_table_access_engine_checker u_chk (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

//--- verification/tb_top.sv
// Purpose: directed bench for the address table access engine
// Assumes: one Wishbone master, registers at byte addresses 0x468..0x494
// Notes:   every command polls busy afterwards until it clears, and load polls it before writing, as software must
`timescale 1ns/10ps
module tb_top;
    reg         sys_clk, rst, cyc, stb, we;
    reg  [11:0] adr;
    reg  [3:0]  sel;
    reg  [31:0] dat_i;
    wire [31:0] dat_o;
    wire        ack;
    int         errors, check_count, cycles;
    localparam [47:0] MAC = 48'h0012_3456_789A;
    address_table_access_engine u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            give_verdict;
        end
    end
    // ****************************************
    // bus and compare helpers
    // ****************************************
    task give_verdict;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check16(input string name, input [15:0] exp, input [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wb(input w, input [11:0] a, input [15:0] d, output [15:0] q);
        @(posedge sys_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {16'h0000, d}; sel <= 4'h3;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = dat_o[15:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
    endtask
    task wr(input [11:0] a, input [15:0] d);
        reg [15:0] q;
        wb(1'b1, a, d, q);
    endtask
    function [11:0] ca(input [2:0] k); ca = 12'h468 + {7'h0, k, 2'b00}; endfunction
    function [11:0] ra(input [2:0] k); ra = 12'h480 + {7'h0, k, 2'b00}; endfunction
    task idle(output [15:0] s);
        do wb(1'b0, ra(5), 16'h0000, s); while (s[15] !== 1'b0);
    endtask
    task load(input [47:0] m, input [15:0] r3, input [15:0] r4);
        reg [15:0] s;
        idle(s);
        wr(ca(0), m[15:0]); wr(ca(1), m[31:16]); wr(ca(2), m[47:32]);
        wr(ca(3), r3); wr(ca(4), r4);
    endtask
    task run(input [15:0] c, input [2:0] code, input string name);
        reg [15:0] s;
        wr(ca(5), c);
        idle(s);
        check16(name, {13'h0, code}, {13'h0, s[14:12]});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        reg [15:0] q;
        for (int k = 0; k < 6; k++) begin
            wb(1'b0, ca(k), 16'h0000, q); check16("cmd_reset", 16'h0000, q);
            wb(1'b0, ra(k), 16'h0000, q); check16("res_reset", 16'h0000, q);
        end
        for (int k = 0; k < 5; k++) wr(ca(k), 16'hA5A0 + k);
        for (int k = 0; k < 5; k++) begin
            wb(1'b0, ca(k), 16'h0000, q); check16("cmd_rw", 16'hA5A0 + k, q);
        end
        wr(ra(0), 16'hFFFF); wb(1'b0, ra(0), 16'h0000, q); check16("res_ro", 16'h0000, q);
        wr(12'h464, 16'h1234); wb(1'b0, 12'h464, 16'h0000, q); check16("unmapped", 16'h0000, q);
    endtask
    task t_create;
        reg [15:0] q;
        load(MAC, 16'h0082, 16'h1055);
        run(16'h0007, 3'h0, "create");
        run(16'h0034, 3'h0, "init_mac");
        run(16'h002C, 3'h0, "search_mac");
        for (int k = 0; k < 3; k++) begin
            wb(1'b0, ra(k), 16'h0000, q); check16("res_mac", MAC[16*k +: 16], q);
        end
        wb(1'b0, ra(3), 16'h0000, q); check16("res_ports", 16'h0082, q);
        wb(1'b0, ra(4), 16'h0000, q); check16("res_info", 16'h0055, q);
        wb(1'b0, ra(5), 16'h0000, q); check16("res_flags", 16'h0003, q);
        run(16'h002C, 3'h2, "search_again");
    endtask
    task t_selectors;
        reg [3:0]  sels [7];
        reg [15:0] q;
        sels = '{4'h9, 4'hA, 4'hC, 4'hE, 4'hD, 4'hB, 4'hF};
        for (int k = 0; k < 7; k++) begin
            run(16'h0030, 3'h0, "init_first");
            run({12'h002, sels[k]}, 3'h0, "search_key");
        end
        run(16'h0030, 3'h0, "init_first");
        run(16'h0020, 3'h0, "search_empty");
        wb(1'b0, ra(5), 16'h0000, q); check16("empty_valid", 16'h0000, {15'h0, q[1]});
    endtask
    task t_over_erase;
        reg [15:0] q;
        load(MAC, 16'h0102, 16'h0055);
        run(16'h000F, 3'h0, "overwrite");
        run(16'h0030, 3'h0, "init_first");
        run(16'h002C, 3'h0, "search_over");
        wb(1'b0, ra(3), 16'h0000, q); check16("over_ports", 16'h0102, q);
        run(16'h001F, 3'h0, "erase");
        run(16'h0030, 3'h0, "init_first");
        run(16'h002C, 3'h2, "search_erased");
    endtask
    task t_full;
        reg [15:0] q;
        for (int k = 0; k < 4; k++) begin
            load({40'h0, 8'h11 * k[7:0]}, 16'h0010, 16'h1000);
            run(16'h0007, 3'h0, "fill_row");
        end
        load(48'h0000_0000_0044, 16'h0010, 16'h1000);
        run(16'h0007, 3'h1, "row_full");
        run(16'h0030, 3'h0, "init_first");
        run(16'h002C, 3'h2, "not_stored");
        load(48'h0000_0000_0055, 16'h0010, 16'h1000);
        wr(ca(5), 16'h0007);
        wb(1'b0, ra(5), 16'h0000, q); check16("busy_set", 16'h0001, {15'h0, q[15]});
        wr(ca(0), 16'hBEEF);
        idle(q);
        wb(1'b0, ca(0), 16'h0000, q); check16("busy_drop", 16'h0055, q);
    endtask
    task t_err;
        reg [15:0] bad [5];
        bad = '{16'h0028, 16'h0031, 16'h0047, 16'h0000, 16'h0015};
        for (int k = 0; k < 5; k++) run(bad[k], 3'h5, "cmd_error");
    endtask
    initial begin
        cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; dat_i = 32'h0000_0000;
        rst = 1'b1; errors = 0; check_count = 0; cycles = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_create;
        t_selectors;
        t_over_erase;
        t_full;
        t_err;
        give_verdict;
    end
endmodule // tb_top
